// ### include/pmbaf_pkg.sv
`default_nettype none

package pmbaf_pkg;

  // ==========================================================================
  // Address and register map
  // ==========================================================================
  localparam logic [3:0] ADDR_FIXED            = 4'h2;
  localparam logic [7:0] OUTPUT_VOLTAGE_FORMAT = 8'h20;
  localparam logic [2:0] LINEAR_MODE           = 3'h0;

  // ==========================================================================
  // Linear field layout
  // ==========================================================================
  localparam int         EXP_W       = 5;
  localparam int         MANT11_W    = 11;
  localparam int         MANT16_W    = 16;
  localparam int         EXP_LSB     = 11;

  // ==========================================================================
  // Byte framing and packet check
  // ==========================================================================
  localparam logic [3:0] BIT_LAST    = 4'h7;
  localparam logic [3:0] BIT_DONE    = 4'h8;
  localparam logic [7:0] CRC_POLY    = 8'h07;
  localparam logic [7:0] CRC_INIT    = 8'h00;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [2:0]  STRAP_RST  = 3'h7;
  localparam logic [7:0]  BYTE_RST   = 8'h00;
  localparam logic [15:0] WORD_RST   = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX   = 3'b001,
    ST_ACK  = 3'b011,
    ST_TX   = 3'b010,
    ST_MACK = 3'b110
  } pmbaf_state_e;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  function automatic logic [15:0] lin11_pack(input logic [4:0] e, input logic [10:0] m);
    return {e, m};
  endfunction

  function automatic logic [7:0] format_byte(input logic [4:0] e);
    return {LINEAR_MODE, e};
  endfunction

endpackage

`default_nettype wire

// ### verilog/pmbaf_top.sv
// Notes on behaviour
// - The slave address is 0010 in bits 6 to 3, with strap pins two, one and zero in bits 2, 1 and 0.
// - A strap pin tied to signal ground reads 0 and an open pin, pulled up, reads 1.
// - The output-voltage format byte returns 000 in bits 7:5 to mark the linear encoding.
// - The output-voltage exponent is a 5-bit signed two's-complement number.
// - Output voltage carries a 16-bit unsigned mantissa, value being mantissa times two to the exponent.
// - Other quantities carry an 11-bit two's-complement mantissa scaled by two to the exponent.
// - Other quantities carry a 5-bit two's-complement exponent chosen per quantity.
// - The alert output is driven while a status or alarm condition is active.
// - Reads end with a packet check byte that the master may use or skip.
`default_nettype none

module pmbaf_top (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        addr_strap_bit0,
  input  wire logic        addr_strap_bit1,
  input  wire logic        addr_strap_bit2,
  input  wire logic        status_active,
  output logic             alert_out_o,
  output logic             alert_out_oe,
  output logic [6:0]       slave_addr_q,
  input  wire logic [4:0]  vout_exp,
  output logic [7:0]       fmt_byte_q,
  input  wire logic [15:0] vout_word,
  output logic [15:0]      vout_mant_q,
  input  wire logic [10:0] lin11_mant,
  input  wire logic [4:0]  lin11_exp,
  output logic [15:0]      lin11_word_q,
  input  wire logic [15:0] lin11_word,
  output logic [10:0]      lin11_mant_q,
  output logic [4:0]       lin11_exp_q
);

  // ==========================================================================
  // Synchronisers
  // ==========================================================================
  logic [2:0] strap_m_q;
  logic [2:0] strap_s_q;
  logic       scl_m_q;
  logic       scl_s_q;
  logic       scl_p_q;
  logic       sda_m_q;
  logic       sda_s_q;
  logic       sda_p_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_m_q <= pmbaf_pkg::STRAP_RST;
      strap_s_q <= pmbaf_pkg::STRAP_RST;
      scl_m_q   <= 1'b1;
      scl_s_q   <= 1'b1;
      scl_p_q   <= 1'b1;
      sda_m_q   <= 1'b1;
      sda_s_q   <= 1'b1;
      sda_p_q   <= 1'b1;
    end else begin
      strap_m_q <= {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
      strap_s_q <= strap_m_q;
      scl_m_q   <= scl_i;
      scl_s_q   <= scl_m_q;
      scl_p_q   <= scl_s_q;
      sda_m_q   <= sda_i;
      sda_s_q   <= sda_m_q;
      sda_p_q   <= sda_s_q;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  assign scl_rise  = scl_s_q & ~scl_p_q;
  assign scl_fall  = ~scl_s_q & scl_p_q;
  assign bus_start = scl_s_q & scl_p_q & ~sda_s_q & sda_p_q;
  assign bus_stop  = scl_s_q & scl_p_q & sda_s_q & ~sda_p_q;

  // ==========================================================================
  // Address, format byte and linear fields
  // ==========================================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slave_addr_q <= {pmbaf_pkg::ADDR_FIXED, pmbaf_pkg::STRAP_RST};
      fmt_byte_q   <= pmbaf_pkg::BYTE_RST;
      vout_mant_q  <= pmbaf_pkg::WORD_RST;
      lin11_word_q <= pmbaf_pkg::WORD_RST;
      lin11_mant_q <= pmbaf_pkg::WORD_RST[10:0];
      lin11_exp_q  <= pmbaf_pkg::WORD_RST[4:0];
    end else begin
      slave_addr_q <= {pmbaf_pkg::ADDR_FIXED, strap_s_q};
      fmt_byte_q   <= pmbaf_pkg::format_byte(vout_exp);
      vout_mant_q  <= vout_word;
      lin11_word_q <= pmbaf_pkg::lin11_pack(lin11_exp, lin11_mant);
      lin11_mant_q <= lin11_word[10:0];
      lin11_exp_q  <= lin11_word[15:pmbaf_pkg::EXP_LSB];
    end
  end

  // ==========================================================================
  // Alert pin
  // ==========================================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alert_out_oe <= 1'b0;
    end else begin
      alert_out_oe <= status_active;
    end
  end

  assign alert_out_o = 1'b0;

  // ==========================================================================
  // Bus slave
  // ==========================================================================
  pmbaf_pkg::pmbaf_state_e state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shreg_q;
  logic [7:0] crc_q;
  logic       is_addr_q;
  logic       rw_q;
  logic       got_cmd_q;
  logic       in_xfer_q;
  logic       tx_sel_q;
  logic       mack_q;
  logic       rx_accept;

  always_comb begin
    if (is_addr_q) begin
      rx_accept = (shreg_q[7:1] == slave_addr_q);
    end else begin
      rx_accept = !got_cmd_q && (shreg_q == pmbaf_pkg::OUTPUT_VOLTAGE_FORMAT);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= pmbaf_pkg::ST_IDLE;
      bit_cnt_q <= 4'h0;
      shreg_q   <= pmbaf_pkg::BYTE_RST;
      crc_q     <= pmbaf_pkg::CRC_INIT;
      is_addr_q <= 1'b0;
      rw_q      <= 1'b0;
      got_cmd_q <= 1'b0;
      in_xfer_q <= 1'b0;
      tx_sel_q  <= 1'b0;
      mack_q    <= 1'b1;
    end else if (bus_start) begin
      state_q   <= pmbaf_pkg::ST_RX;
      bit_cnt_q <= 4'h0;
      is_addr_q <= 1'b1;
      in_xfer_q <= 1'b1;
      tx_sel_q  <= 1'b0;
      if (!in_xfer_q) begin
        crc_q     <= pmbaf_pkg::CRC_INIT;
        got_cmd_q <= 1'b0;
      end
    end else if (bus_stop) begin
      state_q   <= pmbaf_pkg::ST_IDLE;
      in_xfer_q <= 1'b0;
    end else begin
      case (state_q)
        pmbaf_pkg::ST_RX: begin
          if (scl_rise && bit_cnt_q != pmbaf_pkg::BIT_DONE) begin
            shreg_q   <= {shreg_q[6:0], sda_s_q};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == pmbaf_pkg::BIT_DONE) begin
            if (rx_accept) begin
              state_q <= pmbaf_pkg::ST_ACK;
              crc_q   <= pmbaf_pkg::crc8(crc_q, shreg_q);
              if (is_addr_q) begin
                rw_q <= shreg_q[0];
              end else begin
                got_cmd_q <= 1'b1;
              end
            end else begin
              state_q <= pmbaf_pkg::ST_IDLE;
            end
          end
        end
        pmbaf_pkg::ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_q <= 4'h0;
            if (rw_q) begin
              state_q  <= pmbaf_pkg::ST_TX;
              shreg_q  <= fmt_byte_q;
              crc_q    <= pmbaf_pkg::crc8(crc_q, fmt_byte_q);
              tx_sel_q <= 1'b0;
            end else begin
              state_q   <= pmbaf_pkg::ST_RX;
              is_addr_q <= 1'b0;
            end
          end
        end
        pmbaf_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_q == pmbaf_pkg::BIT_LAST) begin
              state_q <= pmbaf_pkg::ST_MACK;
            end else begin
              shreg_q   <= {shreg_q[6:0], 1'b0};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
          end
        end
        pmbaf_pkg::ST_MACK: begin
          if (scl_rise) begin
            mack_q <= sda_s_q;
          end else if (scl_fall) begin
            if (!mack_q && !tx_sel_q) begin
              state_q   <= pmbaf_pkg::ST_TX;
              shreg_q   <= crc_q;
              tx_sel_q  <= 1'b1;
              bit_cnt_q <= 4'h0;
            end else begin
              state_q <= pmbaf_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          state_q <= pmbaf_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign sda_o  = 1'b0;
  assign sda_oe = (state_q == pmbaf_pkg::ST_ACK) || ((state_q == pmbaf_pkg::ST_TX) && !shreg_q[7]);

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_byte_done;
    scl_fall && !bus_start && !bus_stop && state_q == pmbaf_pkg::ST_RX && bit_cnt_q == pmbaf_pkg::BIT_DONE;
  endsequence

  sequence s_addr_byte;
    s_byte_done ##0 is_addr_q;
  endsequence

  a_addr_fixed_bits: assert property (slave_addr_q[6:3] == 4'h2)
    else $error("slave address upper bits wrong");

  a_addr_strap_level: assert property ($past(rst_n, 4) |-> slave_addr_q[2:0] ==
      $past({addr_strap_bit2, addr_strap_bit1, addr_strap_bit0}, 3))
    else $error("strap pins not reflected in address");

  a_format_linear: assert property (##1 fmt_byte_q == {3'h0, $past(vout_exp)})
    else $error("format byte wrong");

  a_vout_exp_signed: assert property (##1 $signed(fmt_byte_q[4:0]) == $signed($past(vout_exp)))
    else $error("exponent field mangled");

  a_vout_mant_pass: assert property (##1 vout_mant_q == $past(vout_word))
    else $error("voltage mantissa not carried");

  a_lin11_pack_dec: assert property (##1 lin11_word_q[10:0] == $past(lin11_mant) &&
      lin11_mant_q == $past(lin11_word[10:0]))
    else $error("linear mantissa wrong");

  a_lin11_exp_field: assert property (##1 lin11_word_q[15:11] == $past(lin11_exp) &&
      lin11_exp_q == $past(lin11_word[15:11]))
    else $error("linear exponent wrong");

  a_addr_match_ack: assert property (s_addr_byte ##0 (shreg_q[7:1] == slave_addr_q) |=> sda_oe)
    else $error("matching address not acknowledged");

  a_addr_foreign_ign: assert property (s_addr_byte ##0 (shreg_q[7:1] != slave_addr_q) |=>
      !sda_oe [*2])
    else $error("foreign address answered");

  a_alert_follows: assert property (status_active |=> alert_out_oe ##0 !alert_out_o)
    else $error("alert not driven");

  a_pec_byte_sent: assert property ($rose(tx_sel_q) |-> shreg_q == $past(crc_q) &&
      state_q == pmbaf_pkg::ST_TX)
    else $error("check byte not sent");

endmodule

`default_nettype wire

// ### dv/pmbaf_master.sv
`default_nettype none

// ==========================================================================
// Bus master model, open drain on SDA, drives SCL
// ==========================================================================
module pmbaf_master (
  input  wire logic clk,
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_drv,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam int HALF = 20;

  initial begin
    scl_drv = 1'b1;
    sda_low = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic scl_up();
    int n;
    n = 0;
    scl_drv = 1'b1;
    while (scl !== 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    if (n == 1000) begin
      tb_top.bad_count++;
      tb_top.stop_test();
    end
  endtask

  task automatic start();
    sda_low = 1'b0;
    hold(HALF);
    scl_up();
    hold(HALF);
    sda_low = 1'b1;
    hold(HALF);
    scl_drv = 1'b0;
    hold(HALF);
  endtask

  task automatic xbit(input logic b, output logic r);
    sda_low = ~b;
    hold(HALF);
    scl_up();
    hold(HALF);
    r = sda;
    scl_drv = 1'b0;
    hold(HALF);
  endtask

  task automatic xbyte(input logic [7:0] d, input logic ack_in, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) xbit(d[i], r[i]);
    xbit(ack_in, ack);
  endtask

  task automatic stop();
    sda_low = 1'b1;
    hold(HALF);
    scl_up();
    hold(HALF);
    sda_low = 1'b0;
    hold(HALF);
  endtask
endmodule

`default_nettype wire

// ### dv/tb_top.sv
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        rst_n;
  logic        scl;
  logic        m_low;
  logic        sda_o;
  logic        sda_oe;
  logic [2:0]  strap;
  logic        stat;
  logic        al_o;
  logic        al_oe;
  logic [6:0]  sadr;
  logic [4:0]  vexp;
  logic [7:0]  fmt;
  logic [15:0] vword;
  logic [15:0] vmant;
  logic [10:0] lmant;
  logic [4:0]  lexp;
  logic [15:0] lword_o;
  logic [15:0] lword;
  logic [10:0] mant_o;
  logic [4:0]  exp_o;
  logic [15:0] obs;
  logic [15:0] exp_q[$];
  int          bad_count;
  int          compares;
  event        res_ev;
  wire logic   sda = (sda_oe ? sda_o : 1'b1) & ~m_low;

  pmbaf_top i_dut (.clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]),
    .status_active(stat), .alert_out_o(al_o), .alert_out_oe(al_oe), .slave_addr_q(sadr),
    .vout_exp(vexp), .fmt_byte_q(fmt), .vout_word(vword), .vout_mant_q(vmant), .lin11_mant(lmant),
    .lin11_exp(lexp), .lin11_word_q(lword_o), .lin11_word(lword), .lin11_mant_q(mant_o),
    .lin11_exp_q(exp_o));

  pmbaf_master i_m (.clk(clk), .scl(scl), .sda(sda), .scl_drv(scl), .sda_low(m_low));

  // ==========================================================================
  // Checking
  // ==========================================================================
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    compares++;
    if (seen !== want) begin
      bad_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, seen, want);
    end
  endtask

  task automatic look(input logic [15:0] want, input logic [15:0] seen);
    exp_q.push_back(want);
    obs = seen;
    -> res_ev;
    #0.1;
  endtask

  initial begin
    forever begin
      @(res_ev);
      check(obs, exp_q.pop_front());
    end
  end

  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++) x = x[7] ? ({x[6:0], 1'b0} ^ 8'h07) : {x[6:0], 1'b0};
    return x;
  endfunction

  // ==========================================================================
  // Bus read: address, command, repeated start, format byte, optional check byte
  // ==========================================================================
  task automatic rd(input logic [6:0] a, input logic pec, input logic [7:0] cmd);
    logic [7:0] r;
    logic [7:0] c;
    logic       k;
    logic       hit;
    logic       ok;
    hit = (a == {pmbaf_pkg::ADDR_FIXED, strap});
    ok = hit && (cmd == pmbaf_pkg::OUTPUT_VOLTAGE_FORMAT);
    c = crc(crc(crc(crc(8'h00, {a, 1'b0}), cmd), {a, 1'b1}), {3'b000, vexp});
    i_m.start();
    i_m.xbyte({a, 1'b0}, 1'b1, r, k);
    look({15'h0, ~hit}, {15'h0, k});
    if (hit) begin
      i_m.xbyte(cmd, 1'b1, r, k);
      look({15'h0, ~ok}, {15'h0, k});
    end
    if (ok) begin
      i_m.start();
      i_m.xbyte({a, 1'b1}, 1'b1, r, k);
      look(16'h0, {15'h0, k});
      i_m.xbyte(8'hff, ~pec, r, k);
      look({8'h0, 3'b000, vexp}, {8'h0, r});
      if (pec) begin
        i_m.xbyte(8'hff, 1'b1, r, k);
        look({8'h0, c}, {8'h0, r});
      end
    end
    i_m.stop();
    i_m.hold(40);
    $display("read at %h done", a);
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    stop_test();
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    rst_n = 1'b0;
    strap = 3'h7;
    {stat, vexp, vword, lmant, lexp, lword} = '0;
    bad_count = 0;
    compares = 0;
    void'($urandom(83));
    repeat (10) @(negedge clk);
    look(16'h0017, {9'h0, sadr});
    rst_n = 1'b1;
    for (int s = 0; s < 8; s++) begin
      strap = 3'(s);
      repeat (4) @(negedge clk);
      look({9'h0, pmbaf_pkg::ADDR_FIXED, strap}, {9'h0, sadr});
    end
    $display("address straps done");
    for (int i = 0; i < 40; i++) begin
      {vexp, vword, lmant} = $urandom;
      {lexp, lword, stat} = 22'($urandom);
      @(negedge clk);
      look({8'h0, 3'b000, vexp}, {8'h0, fmt});
      look(vword, vmant);
      look({lexp, lmant}, lword_o);
      look(lword, {exp_o, mant_o});
      look({15'h0, stat}, {15'h0, al_oe});
      look({15'h0, ~stat}, {15'h0, al_oe ? al_o : 1'b1});
    end
    $display("linear and alert done");
    strap = 3'h2;
    i_m.hold(4);
    for (int i = 0; i < 9; i++) rd(7'h10 + 7'(i), i[0], 8'h20);
    strap = 3'h5;
    i_m.hold(4);
    rd(7'h15, 1'b0, 8'h21);
    rd(7'h15, 1'b1, 8'h20);
    stop_test();
  end
endmodule

`default_nettype wire
